// *** tcbl_consts.svh ***
// Constants for the three-channel breathing LED control block.
// Assumes an 8-bit register address and data path and a 100 MHz clock.
`ifndef TCBL_CONSTS_SVH
`define TCBL_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define TCBL_A_SHUTDOWN 8'h00
`define TCBL_A_BREATH 8'h01
`define TCBL_A_MODE 8'h02
`define TCBL_A_CURRENT 8'h03
`define TCBL_A_DUTY0 8'h04
`define TCBL_A_DUTY_COMMIT 8'h07
`define TCBL_A_DELAY0 8'h0a
`define TCBL_A_RISEHOLD0 8'h10
`define TCBL_A_FALLOFF0 8'h16
`define TCBL_A_TIME_COMMIT 8'h1c
`define TCBL_A_ONOFF 8'h1d
`define TCBL_A_SOFT_RESET 8'h2f
`define TCBL_A_PHASE_STATUS 8'h30
`define TCBL_COMMIT_VALUE 8'h00
// ****************************************
// Field positions and writable masks
// ****************************************
`define TCBL_B_SLEEP 0
`define TCBL_B_ALL_EN 5
`define TCBL_B_RAMP 5
`define TCBL_B_HOLD 4
`define TCBL_B_MODE 5
`define TCBL_M_SHUTDOWN 8'h21
`define TCBL_M_BREATH 8'h30
`define TCBL_M_MODE 8'h20
`define TCBL_M_CURRENT 8'h1c
`define TCBL_M_DELAY 8'hf0
`define TCBL_M_TIME 8'hfe
`define TCBL_MAX_DELAY_CODE 4'ha
`define TCBL_MAX_HOLD_CODE 4'h8
// ****************************************
// Reset values
// ****************************************
`define TCBL_R_SHUTDOWN 8'h01
`define TCBL_R_BREATH 8'h00
`define TCBL_R_MODE 8'h00
`define TCBL_R_CURRENT 8'h00
`define TCBL_R_DUTY 8'h00
`define TCBL_R_TIME 8'h00
`define TCBL_R_ONOFF 3'h7
// ****************************************
// Timing
// ****************************************
`define TCBL_BASE_UNIT_MS 130
`define TCBL_CLK_KHZ 100000
`define TCBL_RAMP_STEPS 256
`define TCBL_TICK_CYCLES ((`TCBL_BASE_UNIT_MS * `TCBL_CLK_KHZ) / `TCBL_RAMP_STEPS)
`endif

// *** tcbl_pkg.sv ***
// Types shared by the breathing LED control block.
// Assumes the constants header is compiled alongside.
package tcbl_pkg;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } tcbl_wr_t;

  typedef struct packed {
    logic [3:0] delay;
    logic [2:0] rise;
    logic [3:0] hold;
    logic [2:0] fall;
    logic [3:0] off;
  } tcbl_timing_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DELAY = 3'b001,
    PH_RISE = 3'b010,
    PH_HOLD = 3'b011,
    PH_FALL = 3'b100,
    PH_OFF = 3'b101
  } tcbl_phase_t;

  typedef struct packed {
    logic [7:0] shutdown;
    logic [7:0] breath;
    logic [7:0] mode;
    logic [7:0] current;
    logic [2:0][7:0] duty;
    logic [2:0][7:0] duty_stage;
    logic [2:0] onoff;
    logic [2:0] onoff_stage;
    logic [2:0][7:0] delay;
    logic [2:0][7:0] delay_stage;
    logic [2:0][7:0] risehold;
    logic [2:0][7:0] risehold_stage;
    logic [2:0][7:0] falloff;
    logic [2:0][7:0] falloff_stage;
  } tcbl_regs_t;
endpackage

// *** tcbl_breath_seq.sv ***
// One channel's breathing sequencer: phase walk and ramp level.
// Assumes a one-cycle tick at 1/256 of the base time unit.
`timescale 1ns/10ps
`include "tcbl_consts.svh"
module tcbl_breath_seq (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire tcbl_pkg::tcbl_timing_t timing_in,
  input wire logic ramp_enable_in,
  input wire logic hold_select_in,
  output logic [8:0] level_out,
  output tcbl_pkg::tcbl_phase_t phase_out
);
  tcbl_pkg::tcbl_phase_t phase, next_phase;
  logic [17:0] cnt, next_cnt, cur_dur, sh;
  logic [8:0] next_level;
  logic holding;

  // Duration in ticks; code 0 is zero only for delay, hold-on and off
  function automatic logic [17:0] f_ticks(input logic [3:0] code, input logic zero_first,
                                          input logic [3:0] max);
    logic [3:0] c;
    c = (code > max) ? max : code;
    if (zero_first && c == 4'h0)
      return 18'h0;
    return 18'h100 << (zero_first ? c - 4'h1 : c); // RULE_19
  endfunction

  always_comb
  begin
    case (phase)
      tcbl_pkg::PH_DELAY: cur_dur = f_ticks(timing_in.delay, 1'b1, `TCBL_MAX_DELAY_CODE);
      tcbl_pkg::PH_RISE: cur_dur = f_ticks({1'b0, timing_in.rise}, 1'b0, 4'h7);
      tcbl_pkg::PH_HOLD: cur_dur = f_ticks(timing_in.hold, 1'b1, `TCBL_MAX_HOLD_CODE);
      tcbl_pkg::PH_FALL: cur_dur = f_ticks({1'b0, timing_in.fall}, 1'b0, 4'h7);
      tcbl_pkg::PH_OFF: cur_dur = f_ticks(timing_in.off, 1'b1, `TCBL_MAX_DELAY_CODE);
      default: cur_dur = 18'h0;
    endcase
    holding = ramp_enable_in && ((phase == tcbl_pkg::PH_HOLD && !hold_select_in) // RULE_13
      || (phase == tcbl_pkg::PH_OFF && hold_select_in)); // RULE_14
    next_phase = phase;
    next_cnt = cnt;
    if (!run_in)
    begin
      next_phase = tcbl_pkg::PH_IDLE;
      next_cnt = 18'h0;
    end
    else if (restart_in || phase == tcbl_pkg::PH_IDLE)
    begin
      next_phase = tcbl_pkg::PH_DELAY; // RULE_08
      next_cnt = 18'h0;
    end
    else if (holding)
      next_cnt = cnt; // RULE_12
    else if (cnt >= cur_dur)
    begin
      next_cnt = 18'h0;
      case (phase)
        tcbl_pkg::PH_DELAY: next_phase = tcbl_pkg::PH_RISE;
        tcbl_pkg::PH_RISE: next_phase = tcbl_pkg::PH_HOLD;
        tcbl_pkg::PH_HOLD: next_phase = tcbl_pkg::PH_FALL;
        tcbl_pkg::PH_FALL: next_phase = tcbl_pkg::PH_OFF;
        tcbl_pkg::PH_OFF: next_phase = tcbl_pkg::PH_RISE; // RULE_09
        default: next_phase = tcbl_pkg::PH_IDLE;
      endcase
    end
    else if (tick_in)
      next_cnt = cnt + 18'h1; // RULE_21
    // Linear ramp: ticks scaled down so every rise or fall spans 256 steps
    sh = cnt >> (phase == tcbl_pkg::PH_FALL ? timing_in.fall : timing_in.rise);
    case (phase)
      tcbl_pkg::PH_RISE: next_level = sh[8:0]; // RULE_21
      tcbl_pkg::PH_HOLD: next_level = 9'h100;
      tcbl_pkg::PH_FALL: next_level = 9'h100 - sh[8:0];
      default: next_level = 9'h0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase <= tcbl_pkg::PH_IDLE;
      cnt <= 18'h0;
      level_out <= 9'h0;
    end
    else
    begin
      phase <= next_phase;
      cnt <= next_cnt;
      level_out <= next_level;
    end
  end

  assign phase_out = phase;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_live;
    run_in && !restart_in;
  endsequence

  delay_once_a: assert property ((phase == tcbl_pkg::PH_OFF) and s_live |=> // RULE_08
    phase inside {tcbl_pkg::PH_OFF, tcbl_pkg::PH_RISE})
    else $error("Delay phase re-entered inside the loop");
  loop_order_a: assert property ((phase == tcbl_pkg::PH_RISE) and s_live |=> // RULE_09
    phase inside {tcbl_pkg::PH_RISE, tcbl_pkg::PH_HOLD})
    else $error("Rise not followed by hold-on");
  peak_hold_a: assert property (phase == tcbl_pkg::PH_HOLD |=> level_out == 9'h100) // RULE_10
    else $error("Hold-on level is not the peak");
  hold_on_stay_a: assert property ((phase == tcbl_pkg::PH_HOLD && ramp_enable_in // RULE_13
    && !hold_select_in) and s_live |=> phase == tcbl_pkg::PH_HOLD)
    else $error("Ramp hold-on left");
  hold_off_stay_a: assert property ((phase == tcbl_pkg::PH_OFF && ramp_enable_in // RULE_14
    && hold_select_in) and s_live |=> phase == tcbl_pkg::PH_OFF ##1 level_out == 9'h0)
    else $error("Ramp off hold left or lit");
endmodule

// *** tcbl_led_ctrl.sv ***
// Three-channel register file, breathing and duty outputs.
// Assumes a register write port already decoded from the serial bus.
//
// Overview of operation
// RULE_01 - Timing writes are staged; writing zero to time commit loads all channels.
// RULE_02 - Channel on/off low three bits light each channel; default all on.
// RULE_03 - Writing zero to the reset register restores every register default.
// RULE_04 - Power-up loads all defaults so outputs start dark.
// RULE_05 - Mode bit clear: each channel duty equals its duty register over 256.
// RULE_06 - Direct mode duty stays constant until the duty register is rewritten.
// RULE_07 - Mode bit set: each channel breathes on its own five periods.
// RULE_08 - Start delay runs once when the sequence begins.
// RULE_09 - Loop is rise, hold-on, fall, off, then back to rise.
// RULE_10 - In breathing mode the duty register sets the ramp peak.
// RULE_11 - Host programs equal periods on all channels to keep a mixed colour.
// RULE_12 - Breathing with ramp enable stops at the state hold select picks.
// RULE_13 - Ramp with hold select clear stays at peak in hold-on forever.
// RULE_14 - Ramp with hold select set falls, then stays dark in off forever.
// RULE_15 - Shutdown keeps all register contents.
// RULE_16 - Software sleep bit turns all current sources off; clearing restores.
// RULE_17 - Low shutdown pin forces hardware shutdown.
// RULE_18 - Duty and on/off writes are staged until zero is written to duty commit.
// RULE_19 - Rise codes 0.13 s doubling to 16.64 s; hold-on code zero is zero.
// RULE_20 - Mode select is bit five of the mode register.
// RULE_21 - One timebase drives all periods; ramps are linear.
`timescale 1ns/10ps
`include "tcbl_consts.svh"
module tcbl_led_ctrl #(
  parameter int TICK_CYCLES = `TCBL_TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire tcbl_pkg::tcbl_wr_t wr_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic shutdown_pin_n_in,
  output logic [7:0] rd_data_out,
  output logic [2:0] channel_drive_out,
  output logic [2:0] current_code_out
);
  // ****************************************
  // Helpers
  // ****************************************
  // Channel index of a three-wide register group, 3 when outside it
  function automatic logic [1:0] f_chan(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] d;
    d = addr - base;
    return (d < 8'h3) ? d[1:0] : 2'h3;
  endfunction

  function automatic tcbl_pkg::tcbl_regs_t f_defaults();
    tcbl_pkg::tcbl_regs_t r;
    r = '0;
    r.shutdown = `TCBL_R_SHUTDOWN;
    r.breath = `TCBL_R_BREATH;
    r.mode = `TCBL_R_MODE;
    r.current = `TCBL_R_CURRENT;
    r.duty = {3{`TCBL_R_DUTY}};
    r.duty_stage = {3{`TCBL_R_DUTY}};
    r.onoff = `TCBL_R_ONOFF;
    r.onoff_stage = `TCBL_R_ONOFF;
    r.delay = {3{`TCBL_R_TIME}};
    r.delay_stage = {3{`TCBL_R_TIME}};
    r.risehold = {3{`TCBL_R_TIME}};
    r.risehold_stage = {3{`TCBL_R_TIME}};
    r.falloff = {3{`TCBL_R_TIME}};
    r.falloff_stage = {3{`TCBL_R_TIME}};
    return r;
  endfunction

  // Breathing output is peak scaled by level/256
  function automatic logic [7:0] f_scale(input logic [7:0] peak, input logic [8:0] lvl);
    logic [16:0] p;
    p = peak * lvl;
    return p[15:8];
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  tcbl_pkg::tcbl_regs_t regs, next_regs;
  logic [1:0] wch;
  logic duty_commit, time_commit, soft_reset;

  always_comb
  begin
    next_regs = regs;
    wch = 2'h3;
    duty_commit = wr_in.en && wr_in.addr == `TCBL_A_DUTY_COMMIT
      && wr_in.data == `TCBL_COMMIT_VALUE;
    time_commit = wr_in.en && wr_in.addr == `TCBL_A_TIME_COMMIT
      && wr_in.data == `TCBL_COMMIT_VALUE;
    soft_reset = wr_in.en && wr_in.addr == `TCBL_A_SOFT_RESET
      && wr_in.data == `TCBL_COMMIT_VALUE;
    if (soft_reset)
      next_regs = f_defaults(); // RULE_03
    else if (duty_commit)
    begin
      next_regs.duty = regs.duty_stage; // RULE_18
      next_regs.onoff = regs.onoff_stage;
    end
    else if (time_commit)
    begin
      next_regs.delay = regs.delay_stage; // RULE_01
      next_regs.risehold = regs.risehold_stage;
      next_regs.falloff = regs.falloff_stage;
    end
    else if (wr_in.en)
    begin
      case (wr_in.addr)
        `TCBL_A_SHUTDOWN: next_regs.shutdown = wr_in.data & `TCBL_M_SHUTDOWN;
        `TCBL_A_BREATH: next_regs.breath = wr_in.data & `TCBL_M_BREATH;
        `TCBL_A_MODE: next_regs.mode = wr_in.data & `TCBL_M_MODE;
        `TCBL_A_CURRENT: next_regs.current = wr_in.data & `TCBL_M_CURRENT;
        `TCBL_A_ONOFF: next_regs.onoff_stage = wr_in.data[2:0]; // RULE_18
        default:
        begin
          wch = f_chan(wr_in.addr, `TCBL_A_DUTY0);
          if (wch != 2'h3)
            next_regs.duty_stage[wch] = wr_in.data; // RULE_06
          wch = f_chan(wr_in.addr, `TCBL_A_DELAY0);
          if (wch != 2'h3)
            next_regs.delay_stage[wch] = wr_in.data & `TCBL_M_DELAY; // RULE_01
          wch = f_chan(wr_in.addr, `TCBL_A_RISEHOLD0);
          if (wch != 2'h3)
            next_regs.risehold_stage[wch] = wr_in.data & `TCBL_M_TIME;
          wch = f_chan(wr_in.addr, `TCBL_A_FALLOFF0);
          if (wch != 2'h3)
            next_regs.falloff_stage[wch] = wr_in.data & `TCBL_M_TIME;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      regs <= f_defaults(); // RULE_04
    else
      regs <= next_regs; // RULE_15
  end

  // ****************************************
  // Timebase and sequencers
  // ****************************************
  logic [15:0] tick_cnt, next_tick_cnt;
  logic tick, breathing;
  logic [2:0][8:0] level;
  tcbl_pkg::tcbl_phase_t [2:0] phase;
  tcbl_pkg::tcbl_timing_t [2:0] timing;

  always_comb
  begin
    tick = tick_cnt == 16'(TICK_CYCLES - 1); // RULE_21
    next_tick_cnt = tick ? 16'h0 : tick_cnt + 16'h1;
    breathing = regs.mode[`TCBL_B_MODE]; // RULE_20
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tick_cnt <= 16'h0;
    else
      tick_cnt <= next_tick_cnt;
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_chan
    assign timing[i] = {regs.delay[i][7:4], regs.risehold[i][7:5], regs.risehold[i][4:1],
      regs.falloff[i][7:5], regs.falloff[i][4:1]};
    // Each channel runs on its own periods; a timing commit restarts it
    tcbl_breath_seq u_seq (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(tick),
      .run_in(breathing), // RULE_07
      .restart_in(time_commit),
      .timing_in(timing[i]),
      .ramp_enable_in(regs.breath[`TCBL_B_RAMP]), // RULE_12
      .hold_select_in(regs.breath[`TCBL_B_HOLD]),
      .level_out(level[i]),
      .phase_out(phase[i])
    );
  end

  // ****************************************
  // Duty generation and outputs
  // ****************************************
  logic [7:0] pwm_cnt, next_pwm_cnt, next_rd_data;
  logic [2:0][7:0] duty_eff;
  logic [2:0] next_drive;
  logic lit_all;

  always_comb
  begin
    next_pwm_cnt = pwm_cnt + 8'h1;
    // Sleep, the all-channel enable and the pin only gate; state keeps running
    lit_all = shutdown_pin_n_in && !regs.shutdown[`TCBL_B_SLEEP] // RULE_16 RULE_17
      && regs.shutdown[`TCBL_B_ALL_EN];
    for (int i = 0; i < 3; i++)
    begin
      duty_eff[i] = breathing ? f_scale(regs.duty[i], level[i]) : regs.duty[i]; // RULE_05 RULE_10
      next_drive[i] = lit_all && regs.onoff[i] && pwm_cnt < duty_eff[i]; // RULE_02
    end
    next_rd_data = 8'h0;
    case (rd_addr_in)
      `TCBL_A_SHUTDOWN: next_rd_data = regs.shutdown;
      `TCBL_A_BREATH: next_rd_data = regs.breath;
      `TCBL_A_MODE: next_rd_data = regs.mode;
      `TCBL_A_CURRENT: next_rd_data = regs.current;
      `TCBL_A_ONOFF: next_rd_data = {5'h0, regs.onoff};
      `TCBL_A_PHASE_STATUS: next_rd_data = {2'h0, 3'(phase[1]), 3'(phase[0])};
      default:
      begin
        if (f_chan(rd_addr_in, `TCBL_A_DUTY0) != 2'h3)
          next_rd_data = regs.duty[f_chan(rd_addr_in, `TCBL_A_DUTY0)];
        if (f_chan(rd_addr_in, `TCBL_A_DELAY0) != 2'h3)
          next_rd_data = regs.delay[f_chan(rd_addr_in, `TCBL_A_DELAY0)];
        if (f_chan(rd_addr_in, `TCBL_A_RISEHOLD0) != 2'h3)
          next_rd_data = regs.risehold[f_chan(rd_addr_in, `TCBL_A_RISEHOLD0)];
        if (f_chan(rd_addr_in, `TCBL_A_FALLOFF0) != 2'h3)
          next_rd_data = regs.falloff[f_chan(rd_addr_in, `TCBL_A_FALLOFF0)];
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwm_cnt <= 8'h0;
      channel_drive_out <= 3'h0;
      rd_data_out <= 8'h0;
      current_code_out <= 3'h0;
    end
    else
    begin
      pwm_cnt <= next_pwm_cnt;
      channel_drive_out <= next_drive;
      rd_data_out <= next_rd_data;
      current_code_out <= regs.current[4:2];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  time_commit_a: assert property (time_commit |=> regs.delay == $past(regs.delay_stage) // RULE_01
    && regs.falloff == $past(regs.falloff_stage))
    else $error("Timing commit did not load staged values");
  onoff_dark_a: assert property (regs.onoff != 3'h7 |=> // RULE_02
    (channel_drive_out & ~$past(regs.onoff)) == 3'h0)
    else $error("Disabled channel driven");
  soft_reset_a: assert property (soft_reset |=> regs.shutdown == `TCBL_R_SHUTDOWN // RULE_03
    && regs.onoff == `TCBL_R_ONOFF ##1 channel_drive_out == 3'h0)
    else $error("Soft reset did not restore defaults");
  direct_duty_a: assert property (!breathing && regs.duty[1] == 8'h0 |-> // RULE_05
    ##1 !channel_drive_out[1])
    else $error("Zero duty channel lit in direct mode");
  duty_hold_a: assert property (wr_in.en && !duty_commit && !soft_reset |=> // RULE_06
    $stable(regs.duty))
    else $error("Duty changed without commit");
  sleep_keep_a: assert property (regs.shutdown[`TCBL_B_SLEEP] && !wr_in.en |=> // RULE_15
    $stable(regs))
    else $error("Registers changed in shutdown");
  sleep_dark_a: assert property (regs.shutdown[`TCBL_B_SLEEP] |=> channel_drive_out == 3'h0) // RULE_16
    else $error("Output lit in software shutdown");
  pin_dark_a: assert property (!shutdown_pin_n_in [*2] |-> channel_drive_out == 3'h0) // RULE_17
    else $error("Output lit with shutdown pin low");
  duty_commit_a: assert property (duty_commit |=> regs.duty == $past(regs.duty_stage) // RULE_18
    && regs.onoff == $past(regs.onoff_stage))
    else $error("Duty commit did not load staged values");
endmodule

// *** tcbl_host_model.sv ***
// Host side model for the LED control block: writes and reads one register byte at a time.
// Assumes one write is taken per rising edge and read data follows the address by one cycle.
`timescale 1ns/10ps
module tcbl_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  output tcbl_pkg::tcbl_wr_t wr_out,
  output logic [7:0] rd_addr_out
);
  initial
  begin
    wr_out = '0;
    rd_addr_out = 8'h00;
  end

  // Idle bus shows inverted bytes so a stale address is never mistaken for a write
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    wr_out = '{en: 1'b1, addr: addr, data: data};
    @(negedge clk_in);
    wr_out = '{en: 1'b0, addr: ~addr, data: ~data};
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_in);
    rd_addr_out = addr;
    @(negedge clk_in);
    data = rd_data_in;
  endtask

  // Same code on all three channels keeps a mixed colour steady
  task automatic program_timing(input logic [7:0] base, input logic [7:0] value);
    for (int i = 0; i < 3; i++)
    begin
      write_reg(base + 8'(i), value);
    end
  endtask
endmodule

// *** tcbl_led_ctrl_test.sv ***
// Self-checking testbench for the three-channel LED control block.
// Assumes a shortened timebase of two clocks per ramp step.
`timescale 1ns/10ps
module tcbl_led_ctrl_test;
  logic clk_in;
  logic rst_n_in;
  logic shutdown_pin_n_in;
  tcbl_pkg::tcbl_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [2:0] drive;
  logic [2:0] code;
  int mismatches;
  int comparisons;

  tcbl_led_ctrl #(.TICK_CYCLES(2)) dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr),
    .rd_addr_in(rd_addr),
    .shutdown_pin_n_in(shutdown_pin_n_in),
    .rd_data_out(rd_data),
    .channel_drive_out(drive),
    .current_code_out(code)
  );

  tcbl_host_model host (
    .clk_in(clk_in),
    .rd_data_in(rd_data),
    .wr_out(wr),
    .rd_addr_out(rd_addr)
  );

  always #5 clk_in = ~clk_in;

  // ****************************************
  // Compare helpers
  // ****************************************
  task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check_cnt(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic expect_reg(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(addr, d);
    check_reg(what, exp, d);
  endtask

  // One full pwm period, so the count equals the effective duty
  task automatic count_on(input int ch, output logic [8:0] n);
    n = '0;
    repeat (256)
    begin
      @(negedge clk_in);
      n = n + 9'(drive[ch]);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_defaults();
    logic [8:0] n;
    expect_reg("shutdown reg", 8'h00, 8'h01);
    expect_reg("mode reg", 8'h02, 8'h00);
    expect_reg("on off reg", 8'h1d, 8'h07);
    count_on(0, n);
    check_cnt("dark after power up", 9'h000, n);
    $display("test_defaults done");
  endtask

  task automatic test_direct();
    logic [8:0] n;
    host.write_reg(8'h00, 8'h20);
    host.write_reg(8'h04, 8'h04);
    host.write_reg(8'h05, 8'h80);
    host.write_reg(8'h06, 8'h80);
    host.write_reg(8'h1d, 8'h05);
    expect_reg("duty before commit", 8'h04, 8'h00);
    expect_reg("on off before commit", 8'h1d, 8'h07);
    host.write_reg(8'h07, 8'h00);
    expect_reg("duty after commit", 8'h04, 8'h04);
    count_on(0, n);
    check_cnt("channel 1 duty", 9'h004, n);
    count_on(1, n);
    check_cnt("channel 2 switched off", 9'h000, n);
    count_on(2, n);
    check_cnt("channel 3 duty", 9'h080, n);
    count_on(0, n);
    check_cnt("channel 1 duty steady", 9'h004, n);
    $display("test_direct done");
  endtask

  task automatic test_shutdown();
    logic [8:0] n;
    shutdown_pin_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    count_on(0, n);
    check_cnt("pin shutdown dark", 9'h000, n);
    expect_reg("duty kept in pin shutdown", 8'h04, 8'h04);
    shutdown_pin_n_in = 1'b1;
    host.write_reg(8'h00, 8'h21);
    count_on(0, n);
    check_cnt("sleep bit dark", 9'h000, n);
    expect_reg("duty kept in sleep", 8'h04, 8'h04);
    host.write_reg(8'h00, 8'h20);
    count_on(0, n);
    check_cnt("duty after wake", 9'h004, n);
    $display("test_shutdown done");
  endtask

  task automatic test_breath_loop();
    logic [2:0] seq [6];
    logic [2:0] exp [6];
    logic [2:0] last;
    int idx;
    exp = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h2};
    host.write_reg(8'h01, 8'h00);
    host.program_timing(8'h0a, 8'h00);
    host.program_timing(8'h10, 8'h00);
    host.program_timing(8'h16, 8'h20);
    expect_reg("fall before commit", 8'h16, 8'h00);
    host.write_reg(8'h1c, 8'h00);
    expect_reg("fall after commit", 8'h16, 8'h20);
    expect_reg("phase idle", 8'h30, 8'h00);
    host.write_reg(8'h02, 8'h20);
    last = 3'h0;
    idx = 0;
    for (int k = 0; k < 4000 && idx < 6; k++)
    begin
      @(negedge clk_in);
      if (rd_data[2:0] !== last)
      begin
        last = rd_data[2:0];
        seq[idx] = last;
        idx++;
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      check_reg("phase order", {5'h00, exp[i]}, {5'h00, seq[i]});
    end
    check_reg("channel 2 phase", 8'h02, {5'h00, rd_data[5:3]});
    $display("test_breath_loop done");
  endtask

  task automatic test_ramp();
    logic [8:0] n;
    host.write_reg(8'h02, 8'h00);
    host.write_reg(8'h01, 8'h20);
    host.write_reg(8'h02, 8'h20);
    repeat (1200) @(negedge clk_in);
    expect_reg("ramp held at peak", 8'h30, 8'h1b);
    count_on(2, n);
    check_cnt("peak equals duty", 9'h080, n);
    host.write_reg(8'h02, 8'h00);
    host.write_reg(8'h01, 8'h30);
    host.write_reg(8'h02, 8'h20);
    repeat (2000) @(negedge clk_in);
    expect_reg("ramp held off", 8'h30, 8'h2d);
    count_on(2, n);
    check_cnt("dark after one cycle", 9'h000, n);
    $display("test_ramp done");
  endtask

  task automatic test_soft_reset();
    host.write_reg(8'h03, 8'hed);
    host.write_reg(8'h2f, 8'h55);
    expect_reg("mode after nonzero reset write", 8'h02, 8'h20);
    expect_reg("current reg masked", 8'h03, 8'h0c);
    check_reg("current code kept", 8'h03, {5'h00, code});
    host.write_reg(8'h2f, 8'h00);
    expect_reg("mode after reset", 8'h02, 8'h00);
    expect_reg("shutdown after reset", 8'h00, 8'h01);
    expect_reg("duty after reset", 8'h04, 8'h00);
    expect_reg("on off after reset", 8'h1d, 8'h07);
    expect_reg("fall after reset", 8'h16, 8'h00);
    check_reg("current code after reset", 8'h00, {5'h00, code});
    $display("test_soft_reset done");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    shutdown_pin_n_in = 1'b1;
    mismatches = 0;
    comparisons = 0;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    test_defaults();
    test_direct();
    test_shutdown();
    test_breath_loop();
    test_ramp();
    test_soft_reset();
    conclude();
  end

  // Whole run needs roughly 7.4k cycles; a hang is cut off well past that
  initial
  begin
    #500000;
    mismatches++;
    conclude();
  end
endmodule
